// ---- core/azt_pkg.sv ----
package azt_pkg;

    // Zone and level geometry
    localparam int          ZONE_W          = 3;
    localparam int          NUM_ZONES       = 5;
    localparam int          NUM_BOUNDS      = 4;
    localparam int          LEVEL_W         = 8;
    localparam int          CNT_W           = 6;
    localparam int          PERIOD_W        = 24;

    // Values after reset or disable
    localparam logic [2:0]  ZONE_RESET      = 3'h0;
    localparam logic [5:0]  CNT_RESET       = 6'h00;

    // Consecutive-period counts
    localparam logic [5:0]  BASE_PERIODS    = 6'h03;
    localparam logic [5:0]  DOWN_EXTRA_BASE = 6'h03;
    localparam logic [1:0]  FAST_PERIODS    = 2'h3;

    // Fast start-up period length
    localparam real         CLOCK_MHZ       = 250.0;
    localparam real         FAST_PERIOD_MS  = 1.1;
    localparam int          FAST_PERIOD_CYC = int'(FAST_PERIOD_MS * 1000.0 * CLOCK_MHZ);

    typedef enum logic [1:0] {
        AZT_DIR_NONE,
        AZT_DIR_UP,
        AZT_DIR_DOWN
    } azt_dir_t;

    typedef enum logic [1:0] {
        AZT_OFF,
        AZT_FAST,
        AZT_RUN
    } azt_state_t;

    // Number of boundaries the level lies above (strict) or at/above (not strict)
    function automatic logic [2:0] azt_count_bounds(input logic [7:0]  level,
                                                    input logic [31:0] bounds,
                                                    input logic        strict);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < NUM_BOUNDS; i++) begin
            if (strict ? (level > bounds[i*8 +: 8]) : (level >= bounds[i*8 +: 8])) begin
                n = n + 3'h1;
            end
        end
        return n;
    endfunction

    // Brightness target of one bank for a zone
    function automatic logic [7:0] azt_pick_target(input logic [39:0] targets,
                                                   input logic [2:0]  zone);
        logic [7:0] t;
        t = targets[7:0];
        for (int i = 0; i < NUM_ZONES; i++) begin
            if (zone == 3'(i)) begin
                t = targets[i*8 +: 8];
            end
        end
        return t;
    endfunction

endpackage

// ---- core/azt_zone_classifier.sv ----
`timescale 1ns/1ps
module azt_zone_classifier
    import azt_pkg::*;
(
    input  wire logic [7:0]  i_level,      // Averaged level of the finished period
    input  wire logic [2:0]  i_prev_zone,  // Zone held so far
    input  wire logic [31:0] i_bound_hi,   // Four upper thresholds, boundary 0 low byte
    input  wire logic [31:0] i_bound_lo,   // Four lower thresholds, boundary 0 low byte
    output logic      [2:0]  o_zone        // Classified zone
);

    // Rising needs the high threshold, falling needs to drop below the low one
    wire logic [2:0] zone_up   = azt_count_bounds(i_level, i_bound_hi, 1'b1);
    wire logic [2:0] zone_down = azt_count_bounds(i_level, i_bound_lo, 1'b0);

    // Between the two thresholds the old zone stands, which is the hysteresis
    assign o_zone = (zone_up > i_prev_zone)   ? zone_up :
                    (zone_down < i_prev_zone) ? zone_down :
                                                i_prev_zone;

endmodule

// ---- core/azt_period_timer.sv ----
`timescale 1ns/1ps
module azt_period_timer
    import azt_pkg::*;
#(
    parameter int FAST_CYC = FAST_PERIOD_CYC
)(
    input  wire logic        i_clock,          // Core clock
    input  wire logic        i_reset,          // Synchronous reset, high
    input  wire logic        i_run,            // Sensing enabled
    input  wire logic [23:0] i_period_cycles,  // Normal period length in cycles
    output logic             o_boundary,       // Last cycle of a period
    output logic             o_fast,           // Current period is a fast one
    output logic             o_last_fast       // Current period is the last fast one
);

    logic [23:0] count;
    logic [1:0]  fast_num;

    // A zero length would never end; treat it as one cycle
    wire logic [23:0] period_len = o_fast ? 24'(FAST_CYC) : i_period_cycles;
    wire logic [23:0] end_count  = (period_len == 24'h000000) ? 24'h000000 : period_len - 24'h000001;

    assign o_fast      = i_run && (fast_num != FAST_PERIODS);
    assign o_last_fast = o_fast && (fast_num == FAST_PERIODS - 2'h1);
    assign o_boundary  = i_run && (count == end_count);

    // Restarts whenever sensing is off so each enable begins with fast periods
    always_ff @(posedge i_clock) begin
        if (i_reset || !i_run) begin
            count    <= 24'h000000;
            fast_num <= 2'h0;
        end else if (o_boundary) begin
            count    <= 24'h000000;
            fast_num <= o_fast ? fast_num + 2'h1 : fast_num;
        end else begin
            count    <= count + 24'h000001;
        end
    end

endmodule

// ---- core/azt_zone_filter.sv ----
`timescale 1ns/1ps
// Function
// - Raise target only after 3 periods of rising, or rise then held.
// - Lower target only after 3 periods of falling, or fall then held.
// - Once qualified, another same-direction change updates target at next boundary.
// - After qualifying, a held or opposite period discards qualification entirely.
// - Averager output zone is that of the last completed full period.
// - Apart from the clear to the lowest zone on disable, target changes happen only at the start of an average period.
// - New target is the zone held in the averager output.
// - On enable, run three fast 1.1 ms periods to settle the zone.
// - Direct and down-delay algorithms share the same qualification logic.
// - Down-delay adds 3 to 34 extra periods, 5-bit code, downward only.
// - Down-delay lowers after base plus extra periods; code 0 needs six.
// - In down-delay mode upward changes still need only three periods.
// - A rise before the down delay completes abandons the pending lower target.
// - Zone state starts at the lowest zone when sensing starts.
// - Level classified into five zones by four hysteretic boundaries.
// - Boundaries shared; each bank picks its own per-zone brightness target.
module azt_zone_filter
    import azt_pkg::*;
#(
    parameter int FAST_CYC = FAST_PERIOD_CYC
)(
    input  wire logic        I_CLOCK,            // 250 MHz core clock
    input  wire logic        I_RESET,            // Synchronous reset, high
    input  wire logic        I_SENSE_EN,         // Ambient light sensing enable
    input  wire logic        I_DOWN_DELAY_MODE,  // 1 selects down-delay, 0 direct
    input  wire logic [4:0]  I_DOWN_DELAY_CODE,  // Extra down periods code
    input  wire logic [23:0] I_PERIOD_CYCLES,    // Normal average period in cycles
    input  wire logic [7:0]  I_AVG_LEVEL,        // Averager level, valid on boundary
    input  wire logic [31:0] I_BOUND_HI,         // Zone boundary high thresholds
    input  wire logic [31:0] I_BOUND_LO,         // Zone boundary low thresholds
    input  wire logic [39:0] I_TARGETS_A,        // Bank A zone targets, zone 0 low byte
    input  wire logic [39:0] I_TARGETS_B,        // Bank B zone targets
    input  wire logic [39:0] I_TARGETS_C,        // Bank C zone targets
    output logic             O_PERIOD_END,       // Period boundary strobe to averager
    output logic             O_FAST_STARTUP,     // Current period is a fast one
    output logic [2:0]       O_AVG_ZONE,         // Averager output zone
    output logic [2:0]       O_TARGET_ZONE,      // Zone the backlight follows
    output logic             O_TARGET_UPDATE,    // Pulse when a change was forced
    output logic             O_QUALIFIED,        // Qualification currently held
    output logic [1:0]       O_PENDING_DIR,      // Direction being counted
    output logic [5:0]       O_PERIOD_COUNT,     // Consecutive periods counted
    output logic [7:0]       O_TARGET_A,         // Bank A brightness target
    output logic [7:0]       O_TARGET_B,         // Bank B brightness target
    output logic [7:0]       O_TARGET_C          // Bank C brightness target
);

    azt_state_t  state;
    azt_state_t  next_state;
    azt_dir_t    dir;
    azt_dir_t    next_dir;
    logic [2:0]  avg_zone;
    logic [2:0]  next_avg_zone;
    logic [2:0]  target_zone;
    logic [2:0]  next_target_zone;
    logic [5:0]  count;
    logic [5:0]  next_count;
    logic        qualified;
    logic        next_qualified;
    logic        update;
    logic        next_update;

    logic        boundary;
    logic        fast;
    logic        last_fast;
    logic [2:0]  new_zone;

    // Period boundaries and fast start-up sequencing
    azt_period_timer #(
        .FAST_CYC        (FAST_CYC)
    ) u_timer (
        .i_clock         (I_CLOCK),
        .i_reset         (I_RESET),
        .i_run           (I_SENSE_EN),
        .i_period_cycles (I_PERIOD_CYCLES),
        .o_boundary      (boundary),
        .o_fast          (fast),
        .o_last_fast     (last_fast)
    );

    // Zone of the period that just completed, hysteresis against the held zone
    azt_zone_classifier u_classify (
        .i_level         (I_AVG_LEVEL),
        .i_prev_zone     (avg_zone),
        .i_bound_hi      (I_BOUND_HI),
        .i_bound_lo      (I_BOUND_LO),
        .o_zone          (new_zone)
    );

    // Direction of the averager output change at this boundary
    wire logic     step_up   = new_zone > avg_zone;
    wire logic     step_down = new_zone < avg_zone;
    wire logic     held      = !step_up && !step_down;
    wire azt_dir_t step_dir  = step_up ? AZT_DIR_UP : AZT_DIR_DOWN;

    // Periods required per direction; only downward moves see the extra delay
    wire logic [5:0] down_extra = DOWN_EXTRA_BASE + {1'b0, I_DOWN_DELAY_CODE};
    wire logic [5:0] req_down   = I_DOWN_DELAY_MODE ? BASE_PERIODS + down_extra
                                                    : BASE_PERIODS;
    wire logic [5:0] req_up     = BASE_PERIODS;
    wire logic [5:0] req_now    = (dir == AZT_DIR_DOWN) ? req_down : req_up;

    // Count after this period if it continues the current run
    wire logic [5:0] count_inc  = count + 6'h01;
    wire logic       reach      = count_inc >= req_now;
    wire logic       same_dir   = !held && (step_dir == dir);
    wire logic       counting   = (dir != AZT_DIR_NONE);

    // Decisions taken only on a period boundary, normal in RUN or fast in FAST
    wire logic run_edge  = (state == AZT_RUN) && boundary;
    wire logic fast_edge = (state == AZT_FAST) && boundary;

    // Main sequencing; apart from enable and disable, every change lands on the boundary cycle only
    always_comb begin
        next_state       = state;
        next_dir         = dir;
        next_avg_zone    = avg_zone;
        next_target_zone = target_zone;
        next_count       = count;
        next_qualified   = qualified;
        next_update      = 1'b0;
        case (state)
            AZT_OFF: begin
                // Fresh start from the lowest zone, nothing pending
                next_avg_zone    = ZONE_RESET;
                next_target_zone = ZONE_RESET;
                next_dir         = AZT_DIR_NONE;
                next_count       = CNT_RESET;
                next_qualified   = 1'b0;
                if (I_SENSE_EN) begin
                    next_state = AZT_FAST;
                end
            end
            AZT_FAST: begin
                // Fast periods let the backlight follow the zone without filtering
                if (fast_edge) begin
                    next_avg_zone    = new_zone;
                    next_target_zone = new_zone;
                    next_update      = (new_zone != target_zone);
                    if (last_fast) begin
                        next_state = AZT_RUN;
                    end
                end
            end
            AZT_RUN: begin
                if (run_edge) begin
                    // Output register takes the completed period's zone
                    next_avg_zone = new_zone;
                    if (held) begin
                        if (qualified) begin
                            // A pause after qualifying forfeits it
                            next_dir       = AZT_DIR_NONE;
                            next_count     = CNT_RESET;
                            next_qualified = 1'b0;
                        end else if (counting) begin
                            // Holding at the new zone counts toward the run
                            next_count = count_inc;
                            if (reach) begin
                                next_target_zone = new_zone;
                                next_qualified   = 1'b1;
                                next_update      = 1'b1;
                            end
                        end
                    end else if (same_dir && qualified) begin
                        // Further change in the same direction moves at once
                        next_target_zone = new_zone;
                        next_update      = 1'b1;
                    end else if (same_dir) begin
                        next_count = count_inc;
                        if (reach) begin
                            next_target_zone = new_zone;
                            next_qualified   = 1'b1;
                            next_update      = 1'b1;
                        end
                    end else begin
                        // Reversal: drop what was pending and count afresh
                        next_dir       = step_dir;
                        next_count     = 6'h01;
                        next_qualified = 1'b0;
                    end
                end
            end
            default: begin
                next_state = AZT_OFF;
            end
        endcase
        // Turning sensing off wins over anything else this cycle
        if (!I_SENSE_EN) begin
            next_state       = AZT_OFF;
            next_avg_zone    = ZONE_RESET;
            next_target_zone = ZONE_RESET;
            next_dir       = AZT_DIR_NONE;
            next_count     = CNT_RESET;
            next_qualified = 1'b0;
            next_update    = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            state       <= AZT_OFF;
            dir         <= AZT_DIR_NONE;
            avg_zone    <= ZONE_RESET;
            target_zone <= ZONE_RESET;
            count       <= CNT_RESET;
            qualified   <= 1'b0;
            update      <= 1'b0;
        end else begin
            state       <= next_state;
            dir         <= next_dir;
            avg_zone    <= next_avg_zone;
            target_zone <= next_target_zone;
            count       <= next_count;
            qualified   <= next_qualified;
            update      <= next_update;
        end
    end

    // Boundary strobe and fast flag, registered so the averager sees clean levels
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            O_PERIOD_END   <= 1'b0;
            O_FAST_STARTUP <= 1'b0;
        end else begin
            O_PERIOD_END   <= boundary;
            O_FAST_STARTUP <= fast;
        end
    end

    // Per-bank targets; zone targets are live, so a rewrite shows one cycle later
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            O_TARGET_A <= 8'h00;
            O_TARGET_B <= 8'h00;
            O_TARGET_C <= 8'h00;
        end else begin
            O_TARGET_A <= azt_pick_target(I_TARGETS_A, target_zone);
            O_TARGET_B <= azt_pick_target(I_TARGETS_B, target_zone);
            O_TARGET_C <= azt_pick_target(I_TARGETS_C, target_zone);
        end
    end

    // Status straight from the state registers
    assign O_AVG_ZONE      = avg_zone;
    assign O_TARGET_ZONE   = target_zone;
    assign O_TARGET_UPDATE = update;
    assign O_QUALIFIED     = qualified;
    assign O_PENDING_DIR   = dir;
    assign O_PERIOD_COUNT  = count;

endmodule

// ---- sim/azt_avg_model.sv ----
`timescale 1ns/1ps
module azt_avg_model (
    input  wire logic       i_clock,       // Core clock
    input  wire logic       i_sense_en,    // Sensing enable
    input  wire logic       i_period_end,  // Boundary strobe from the filter
    input  wire logic [2:0] i_zone,        // Zone the next period averages to
    output logic      [7:0] o_level        // Averaged level held for a period
);
    // One level per zone, clear of both thresholds of every boundary
    function automatic logic [7:0] mid(input logic [2:0] z);
        return (z == 3'h0) ? 8'h10 : (z == 3'h1) ? 8'h50 : (z == 3'h2) ? 8'h80 : (z == 3'h3) ? 8'hC0 : 8'hF0;
    endfunction
    initial o_level = 8'h10;
    // New level only after a boundary or while disabled, so each period shows one whole average
    always @(posedge i_clock) begin
        if (i_period_end || !i_sense_en) begin
            o_level <= mid(i_zone);
        end
    end
endmodule

// ---- sim/azt_zone_filter_chk.sv ----
`timescale 1ns/1ps
module azt_zone_filter_chk (
    input wire logic        I_CLOCK,            // Core clock
    input wire logic        I_RESET,            // Synchronous reset
    input wire logic        I_SENSE_EN,         // Sensing enable
    input wire logic        I_DOWN_DELAY_MODE,  // Down-delay select
    input wire logic [4:0]  I_DOWN_DELAY_CODE,  // Extra down periods code
    input wire logic [39:0] I_TARGETS_A,        // Bank A zone targets
    input wire logic        O_PERIOD_END,       // Boundary strobe
    input wire logic        O_FAST_STARTUP,     // Fast period flag
    input wire logic [2:0]  O_AVG_ZONE,         // Averager output zone
    input wire logic [2:0]  O_TARGET_ZONE,      // Followed zone
    input wire logic        O_TARGET_UPDATE,    // Change pulse
    input wire logic        O_QUALIFIED,        // Qualification held
    input wire logic [1:0]  O_PENDING_DIR,      // Counted direction
    input wire logic [5:0]  O_PERIOD_COUNT,     // Consecutive periods
    input wire logic [7:0]  O_TARGET_A          // Bank A brightness
);
    logic [7:0] exp_a;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);
    // Bank A lookup one cycle behind the zone, as the bank output is
    always_ff @(posedge I_CLOCK) begin
        exp_a <= I_TARGETS_A[O_TARGET_ZONE*8 +: 8];
    end
    // Zones may only move on a boundary; a clear by disable is excused
    a_target_moves: assert property (
        $changed(O_TARGET_ZONE) && $past(I_SENSE_EN) |-> O_PERIOD_END) else $error("target moved off boundary");
    a_avg_moves: assert property (
        $changed(O_AVG_ZONE) && $past(I_SENSE_EN) |-> O_PERIOD_END) else $error("avg zone moved off boundary");
    a_update_points: assert property (
        O_TARGET_UPDATE |-> O_PERIOD_END && O_TARGET_ZONE == O_AVG_ZONE) else $error("update not to avg zone");
    // Fresh qualification needs exactly the consecutive count of its mode
    a_update_count: assert property (
        O_TARGET_UPDATE && !$past(O_QUALIFIED) && !O_FAST_STARTUP && !$past(O_FAST_STARTUP)
        |-> O_QUALIFIED && O_PERIOD_COUNT == ((O_PENDING_DIR == 2'h2 && I_DOWN_DELAY_MODE)
            ? {1'b0, I_DOWN_DELAY_CODE} + 6'h06 : 6'h03)) else $error("update at wrong count");
    a_held_drops: assert property (
        $past(O_QUALIFIED) && O_PERIOD_END && $past(I_SENSE_EN) && O_AVG_ZONE == $past(O_AVG_ZONE)
        |-> !O_QUALIFIED && O_PENDING_DIR == 2'h0 && !O_TARGET_UPDATE) else $error("held kept qualification");
    a_same_dir: assert property (
        $past(O_QUALIFIED) && O_PERIOD_END && $past(I_SENSE_EN) &&
        (($past(O_PENDING_DIR) == 2'h1 && O_AVG_ZONE > $past(O_AVG_ZONE)) ||
         ($past(O_PENDING_DIR) == 2'h2 && O_AVG_ZONE < $past(O_AVG_ZONE)))
        |-> O_TARGET_UPDATE && O_TARGET_ZONE == O_AVG_ZONE) else $error("qualified change not followed");
    a_off_clears: assert property (
        !I_SENSE_EN |=> O_PERIOD_COUNT == 6'h00 && !O_QUALIFIED && O_PENDING_DIR == 2'h0 && O_AVG_ZONE == 3'h0)
        else $error("disable left state");
    a_bank_follow: assert property (
        I_SENSE_EN && $past(I_SENSE_EN) && $past(I_SENSE_EN, 2) && $past(I_SENSE_EN, 3) |-> O_TARGET_A == exp_a)
        else $error("bank A target wrong");
endmodule
bind azt_zone_filter azt_zone_filter_chk u_chk (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_SENSE_EN(I_SENSE_EN), .I_DOWN_DELAY_MODE(I_DOWN_DELAY_MODE),
    .I_DOWN_DELAY_CODE(I_DOWN_DELAY_CODE), .I_TARGETS_A(I_TARGETS_A), .O_PERIOD_END(O_PERIOD_END),
    .O_FAST_STARTUP(O_FAST_STARTUP), .O_AVG_ZONE(O_AVG_ZONE), .O_TARGET_ZONE(O_TARGET_ZONE),
    .O_TARGET_UPDATE(O_TARGET_UPDATE), .O_QUALIFIED(O_QUALIFIED), .O_PENDING_DIR(O_PENDING_DIR),
    .O_PERIOD_COUNT(O_PERIOD_COUNT), .O_TARGET_A(O_TARGET_A));

// ---- sim/test_azt_zone_filter.sv ----
`timescale 1ns/1ps
module test_azt_zone_filter;
    import azt_pkg::*;
    localparam int          FAST  = 20;
    localparam int          NORM  = 16;
    localparam logic [39:0] TGT_A = 40'hF1C2936435;
    localparam logic [39:0] TGT_B = 40'hE0B0704020;
    logic        clk, rst, en, mode, upd, per_end, fast, qual;
    logic [4:0]  code;
    logic [2:0]  zq, exp_t, avg_z, tgt_z;
    logic [7:0]  level, ta, tb, tc_o;
    logic [39:0] tc;
    logic [1:0]  dir;
    logic [5:0]  cnt;
    logic        have_t;
    int          failures, check_count, gap;
    azt_zone_filter #(.FAST_CYC(FAST)) dut (.I_CLOCK(clk), .I_RESET(rst), .I_SENSE_EN(en),
        .I_DOWN_DELAY_MODE(mode), .I_DOWN_DELAY_CODE(code), .I_PERIOD_CYCLES(24'(NORM)), .I_AVG_LEVEL(level),
        .I_BOUND_HI(32'hDCA16A35), .I_BOUND_LO(32'hCC996633), .I_TARGETS_A(TGT_A), .I_TARGETS_B(TGT_B),
        .I_TARGETS_C(tc), .O_PERIOD_END(per_end), .O_FAST_STARTUP(fast), .O_AVG_ZONE(avg_z),
        .O_TARGET_ZONE(tgt_z), .O_TARGET_UPDATE(upd), .O_QUALIFIED(qual), .O_PENDING_DIR(dir),
        .O_PERIOD_COUNT(cnt), .O_TARGET_A(ta), .O_TARGET_B(tb), .O_TARGET_C(tc_o));
    azt_avg_model avg (.i_clock(clk), .i_sense_en(en), .i_period_end(per_end), .i_zone(zq), .o_level(level));
    // 250 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One averaged period: zone z offered, then the boundary result is judged
    task automatic walk(input logic [2:0] z, input logic [2:0] t, input logic u, input int len);
        zq = z;
        @(posedge clk);
        #1;
        if (have_t) chk(ta === TGT_A[exp_t*8 +: 8] && tb === TGT_B[exp_t*8 +: 8] && tc_o === tc[exp_t*8 +: 8], "banks");
        gap = 1;
        do begin
            @(posedge clk);
            #1;
            gap++;
        end while (per_end !== 1'b1 && gap < 100);
        chk(per_end === 1'b1 && (len == 0 || gap == len), "period length");
        chk(avg_z === z, "averager zone");
        chk(tgt_z === t && upd === u, "target zone or update");
        exp_t = t;
        have_t = 1'b1;
    endtask
    task automatic t_start();
        chk(avg_z === 3'h0 && tgt_z === 3'h0 && cnt === 6'h00 && qual === 1'b0, "reset state");
        en = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(fast === 1'b1, "fast flag");
        walk(3'h4, 3'h4, 1'b1, 0);
        walk(3'h4, 3'h4, 1'b0, FAST);
        walk(3'h4, 3'h4, 1'b0, FAST);
        walk(3'h4, 3'h4, 1'b0, NORM);
        chk(fast === 1'b0, "fast flag after three");
        $display("start-up done");
    endtask
    task automatic t_direct();
        logic [2:0] zs [11] = '{3'h3, 3'h3, 3'h2, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4};
        logic [2:0] ts [11] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h1, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4};
        logic [10:0] us = 11'b10001001100;
        mode = 1'b0;
        for (int i = 0; i < 11; i++) begin
            walk(zs[i], ts[i], us[i], NORM);
            if (i == 1) chk(cnt === 6'h02 && dir === AZT_DIR_DOWN && qual === 1'b0, "down count");
        end
        $display("direct walk done");
    endtask
    task automatic t_delay();
        logic [2:0] zs [12] = '{3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1};
        logic [2:0] ts [12] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h1};
        logic [11:0] us = 12'b100000100000;
        mode = 1'b1;
        code = 5'h00;
        for (int i = 0; i < 12; i++) begin
            walk(zs[i], ts[i], us[i], NORM);
        end
        $display("down-delay walk done");
    endtask
    task automatic t_disable();
        en = 1'b0;
        zq = 3'h2;
        @(posedge clk);
        #1;
        chk(cnt === 6'h00 && qual === 1'b0 && dir === AZT_DIR_NONE && avg_z === 3'h0, "disable clear");
        have_t = 1'b0;
        tc = 40'h0A1B2C3D4E;
        en = 1'b1;
        walk(3'h2, 3'h2, 1'b1, 0);
        walk(3'h2, 3'h2, 1'b0, FAST);
        $display("disable restart done");
    endtask
    // Whole run is under a thousand cycles; this cuts a hang short
    initial begin
        #20000;
        failures++;
        stop_test();
    end
    initial begin
        rst = 1'b1;
        en = 1'b0;
        mode = 1'b0;
        code = 5'h00;
        zq = 3'h4;
        tc = 40'h5A4B3C2D1E;
        have_t = 1'b0;
        exp_t = 3'h0;
        failures = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_start();
        t_direct();
        t_delay();
        t_disable();
        stop_test();
    end
endmodule
